// *** pkg/sdw_pkg.sv ***
// Purpose: constants and carrier types of the write-burst path
// Assumes: one 25 MHz clock, synchronous active-high reset
// Notes:   register layout is shared by the bus slave and its users
// Notes on behaviour
// RULE_01: Write latency is additive latency plus column latency minus one clock.
// RULE_02: Address bit ten high at write means automatic precharge after the burst.
// RULE_03: First element on first rising strobe edge, then every strobe edge.
// RULE_04: Controller holds strobe low before first rise and after last element.
// RULE_05: Controller places strobe rises at latency, within a quarter clock.
// RULE_06: After a burst the data lines stay undriven and extra data is dropped.
// RULE_07: Write issued half a burst later continues data without a gap.
// RULE_08: Controller never interrupts a four-element burst.
// RULE_09: Eight-element burst without precharge truncated only by a write two clocks later.
// RULE_10: Controller issues no precharge to either bank during a truncation.
// RULE_11: Interrupting write keeps its own auto precharge selection.
// RULE_12: Controller counts recovery from the full programmed burst end.
// RULE_13: Controller waits write-to-read delay, at least two clocks, before a read.
// RULE_14: Write-to-read wait applies within a device, not between ranks.
// RULE_15: Controller waits write recovery before precharging the written bank.
// RULE_16: Precharge to another bank needs no recovery wait.
// RULE_17: Controller keeps concurrent auto precharge spacing to other banks.
// RULE_18: Recovery field in mode bits eleven to nine times the auto precharge.
// RULE_19: Lower strobe times lower byte, upper strobe times upper byte.
// RULE_20: Masked element leaves the array location unchanged.
// RULE_21: Controller keeps clock enable high until the burst completes.
// RULE_22: Bank from bank select inputs, column from low address bits.
// RULE_23: Write decoded from select and strobe pins with clock enable high.
package sdw_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [3:0]  REG_CFG         = 4'h0;
    localparam logic [3:0]  REG_STATUS      = 4'h4;
    localparam logic [3:0]  REG_MEM_INDEX   = 4'h8;
    localparam logic [3:0]  REG_MEM_DATA    = 4'hC;

    localparam int          CFG_ADD_LAT_LSB = 0;
    localparam int          CFG_COL_LAT_LSB = 4;
    localparam int          CFG_BURST8_BIT  = 8;
    localparam int          CFG_RECOV_LSB   = 9;
    localparam int          CFG_WIDTH       = 12;
    localparam logic [11:0] CFG_RESET       = 12'h630;

    localparam int          STAT_ACTIVE_BIT = 0;
    localparam int          STAT_RECOV_BIT  = 1;
    localparam int          STAT_BANK_LSB   = 4;
    localparam int          STAT_COUNT_LSB  = 8;

    // ************************************************************
    // Structure and timing
    // ************************************************************
    localparam int          LANES           = 2;
    localparam int          SCHED_DEPTH     = 16;
    localparam int          MEM_DEPTH       = 64;
    localparam logic [3:0]  BURST_SHORT     = 4'h4;
    localparam logic [3:0]  BURST_LONG      = 4'h8;
    localparam logic [2:0]  RECOV_MIN       = 3'h1;

    typedef struct packed {
        logic        clkEnable;
        logic        chipSelectN;
        logic        rowStrobeN;
        logic        colStrobeN;
        logic        writeEnableN;
        logic [1:0]  bankSelect;
        logic [12:0] addr;
    } sdw_cmd_t;

    typedef struct packed {
        logic       valid;
        logic [1:0] bank;
        logic [3:0] col;
        logic       autoPre;
    } sdw_slot_t;

    typedef struct packed {
        logic                  on;
        logic [1:0]            bank;
        logic [3:0]            col;
        logic                  autoPre;
        logic [3:0]            limit;
        logic [LANES-1:0][3:0] cnt;
    } sdw_burst_t;

    typedef struct packed {
        logic       on;
        logic [1:0] bank;
        logic [2:0] count;
    } sdw_recov_t;

endpackage

// *** src/sdw_lane.sv ***
// Purpose: one byte lane, captures data on its own strobe edges
// Assumes: strobe, data and mask are pins from outside the clock domain
// Notes:   edges are seen on the synchronised strobe level
`timescale 1ns/1ns
module sdw_lane (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       laneOpen,
    input  wire logic       strobePin,
    input  wire logic [7:0] dataPin,
    input  wire logic       maskPin,
    output logic            capValid,
    output logic [7:0]      capData,
    output logic            capMask
);
    typedef struct packed {
        logic [9:0] sync1;
        logic [9:0] sync2;
        logic       prevStrobe;
        logic       armed;
        logic       valid;
        logic [7:0] data;
        logic       mask;
    } sdw_lane_t;

    sdw_lane_t st;
    sdw_lane_t next_st;
    logic      rise;
    logic      fall;

    always_comb begin
        next_st = st;
        next_st.sync1 = {strobePin, maskPin, dataPin};
        next_st.sync2 = st.sync1;
        next_st.prevStrobe = st.sync2[9];
        rise = st.sync2[9] & ~st.prevStrobe;
        fall = ~st.sync2[9] & st.prevStrobe;
        // Preamble low: falling edges before the first rise are ignored
        next_st.armed = laneOpen & (st.armed | rise); // RULE_03
        next_st.valid = laneOpen & (rise | (fall & st.armed)); // RULE_03
        next_st.data = st.sync2[7:0];
        next_st.mask = st.sync2[8];
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign capValid = st.valid;
    assign capData  = st.data;
    assign capMask  = st.mask;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    firstRise_a: assert property (laneOpen && !st.armed && fall |=> !capValid) // RULE_03
        else $error("Lane captured on a falling edge before the first rise");
endmodule

// *** src/sdw_write_burst.sv ***
// Purpose: write-burst path of a four-bank DDR memory device
// Assumes: controller keeps strobe, clock enable and command spacing legal
// Notes:   small array stands in for the storage cells
//
// Chosen here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ns
module sdw_write_burst (
    input  wire logic                clk,
    input  wire logic                srst,
    input  wire logic [3:0]          avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [31:0]         avs_writedata,
    output logic [31:0]              avs_readdata,
    output logic                     avs_waitrequest,
    input  wire sdw_pkg::sdw_cmd_t   cmdPins,
    input  wire logic [15:0]         dataIn,
    input  wire logic [1:0]          byteMaskInput,
    input  wire logic                lowerByteStrobe,
    input  wire logic                upperByteStrobe,
    output logic [15:0]              dataOut,
    output logic                     dataOe,
    output logic                     autoPrechargeStrobe,
    output logic [1:0]               autoPrechargeBank
);
    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        sdw_pkg::sdw_cmd_t                              cmdSync1;
        sdw_pkg::sdw_cmd_t                              cmdSync2;
        logic [sdw_pkg::CFG_WIDTH-1:0]                  cfg;
        logic [5:0]                                     memIndex;
        sdw_pkg::sdw_slot_t [sdw_pkg::SCHED_DEPTH-1:0]  sched;
        sdw_pkg::sdw_burst_t                            burst;
        sdw_pkg::sdw_recov_t                            recov;
        logic                                           apPulse;
        logic [1:0]                                     apBank;
        logic [7:0]                                     writeCount;
        logic                                           ack;
        logic [31:0]                                    readData;
    } sdw_state_t;

    sdw_state_t                       st;
    sdw_state_t                       next_st;
    logic [7:0]                       mem [sdw_pkg::LANES][sdw_pkg::MEM_DEPTH];
    logic [sdw_pkg::LANES-1:0]        capValid;
    logic [sdw_pkg::LANES-1:0]        capMask;
    logic [sdw_pkg::LANES-1:0][7:0]   capData;
    logic [sdw_pkg::LANES-1:0]        strobes;
    logic [sdw_pkg::LANES-1:0]        memWe;
    logic [sdw_pkg::LANES-1:0][5:0]   memAddr;
    logic                             isWrite;
    logic [3:0]                       writeLatency;
    logic [2:0]                       recovery;
    logic                             burstLenEight;
    logic                             burstDone;
    logic                             busReq;

    // Element slot inside the burst, wrapping in its aligned block
    function automatic logic [5:0] slotOf(input sdw_pkg::sdw_burst_t b, input logic [3:0] n, input logic eight);
        logic [2:0] off;
        off = b.col[2:0] + n[2:0];
        slotOf = eight ? {b.bank, b.col[3], off} : {b.bank, b.col[3:2], off[1:0]};
    endfunction

    // ************************************************************
    // Byte lanes
    // ************************************************************
    assign strobes = {upperByteStrobe, lowerByteStrobe};

    for (genvar l = 0; l < sdw_pkg::LANES; l++) begin : gLane
        sdw_lane uLane ( // RULE_19
            .clk       (clk),
            .srst      (srst),
            .laneOpen  (st.burst.on),
            .strobePin (strobes[l]),
            .dataPin   (dataIn[8*l +: 8]),
            .maskPin   (byteMaskInput[l]),
            .capValid  (capValid[l]),
            .capData   (capData[l]),
            .capMask   (capMask[l])
        );
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        next_st = st;
        memWe = '0;
        memAddr = '0;
        next_st.cmdSync1 = cmdPins;
        next_st.cmdSync2 = st.cmdSync1;
        isWrite = st.cmdSync2.clkEnable & ~st.cmdSync2.chipSelectN & st.cmdSync2.rowStrobeN
                  & ~st.cmdSync2.colStrobeN & ~st.cmdSync2.writeEnableN; // RULE_23
        writeLatency = {1'b0, st.cfg[sdw_pkg::CFG_ADD_LAT_LSB +: 3]}
                       + {1'b0, st.cfg[sdw_pkg::CFG_COL_LAT_LSB +: 3]} - 4'h1; // RULE_01
        recovery = st.cfg[sdw_pkg::CFG_RECOV_LSB +: 3];
        burstLenEight = st.cfg[sdw_pkg::CFG_BURST8_BIT];

        // Latency line: each command walks down to slot zero
        for (int i = 0; i < sdw_pkg::SCHED_DEPTH - 1; i++) begin
            next_st.sched[i] = st.sched[i + 1];
        end
        next_st.sched[sdw_pkg::SCHED_DEPTH-1] = '0;
        if (isWrite && writeLatency != 4'h0) begin
            next_st.sched[writeLatency - 4'h1] = {1'b1, st.cmdSync2.bankSelect,
                                                  st.cmdSync2.addr[3:0], st.cmdSync2.addr[10]}; // RULE_01 RULE_22 RULE_02
        end

        // Captured elements beyond the burst length are dropped
        for (int l = 0; l < sdw_pkg::LANES; l++) begin
            if (capValid[l] && st.burst.on && st.burst.cnt[l] < st.burst.limit) begin // RULE_06
                memWe[l] = ~capMask[l]; // RULE_20
                memAddr[l] = slotOf(st.burst, st.burst.cnt[l], burstLenEight);
                next_st.burst.cnt[l] = st.burst.cnt[l] + 4'h1; // RULE_03
            end
        end
        burstDone = st.burst.on;
        for (int l = 0; l < sdw_pkg::LANES; l++) begin
            burstDone = burstDone & (next_st.burst.cnt[l] == st.burst.limit);
        end

        // Recovery countdown ahead of the internal precharge
        next_st.apPulse = 1'b0;
        if (st.recov.on) begin
            if (st.recov.count <= sdw_pkg::RECOV_MIN) begin
                next_st.apPulse = 1'b1; // RULE_02
                next_st.apBank = st.recov.bank;
                next_st.recov.on = 1'b0;
            end else begin
                next_st.recov.count = st.recov.count - 3'h1;
            end
        end
        if (burstDone) begin
            next_st.burst.on = 1'b0;
            if (st.burst.autoPre) begin
                next_st.recov.on = 1'b1; // RULE_02
                next_st.recov.bank = st.burst.bank;
                next_st.recov.count = (recovery == 3'h0) ? sdw_pkg::RECOV_MIN : recovery; // RULE_18
            end
        end

        // A start takes over the lanes: concatenation or truncation at four
        if (st.sched[0].valid) begin
            next_st.burst.on = 1'b1; // RULE_07 RULE_09
            next_st.burst.bank = st.sched[0].bank; // RULE_22
            next_st.burst.col = st.sched[0].col;
            next_st.burst.autoPre = st.sched[0].autoPre; // RULE_11
            next_st.burst.limit = burstLenEight ? sdw_pkg::BURST_LONG : sdw_pkg::BURST_SHORT;
            next_st.burst.cnt = '0;
            next_st.writeCount = st.writeCount + 8'h1;
        end

        // Bus slave: one wait state, then the answer
        busReq = avs_read | avs_write;
        next_st.ack = busReq & ~st.ack;
        // Write lands only at the edge where waitrequest is seen low
        if (avs_write && st.ack) begin
            case (avs_address)
                sdw_pkg::REG_CFG: begin
                    next_st.cfg = avs_writedata[sdw_pkg::CFG_WIDTH-1:0];
                end
                sdw_pkg::REG_MEM_INDEX: begin
                    next_st.memIndex = avs_writedata[5:0];
                end
                default: begin
                end
            endcase
        end
        if (busReq && !st.ack) begin
            next_st.readData = '0;
            if (avs_read) begin
                case (avs_address)
                    sdw_pkg::REG_CFG: begin
                        next_st.readData[sdw_pkg::CFG_WIDTH-1:0] = st.cfg;
                    end
                    sdw_pkg::REG_STATUS: begin
                        next_st.readData[sdw_pkg::STAT_ACTIVE_BIT] = st.burst.on;
                        next_st.readData[sdw_pkg::STAT_RECOV_BIT] = st.recov.on;
                        next_st.readData[sdw_pkg::STAT_BANK_LSB +: 2] = st.burst.bank;
                        next_st.readData[sdw_pkg::STAT_COUNT_LSB +: 8] = st.writeCount;
                    end
                    sdw_pkg::REG_MEM_INDEX: begin
                        next_st.readData[5:0] = st.memIndex;
                    end
                    sdw_pkg::REG_MEM_DATA: begin
                        next_st.readData[15:0] = {mem[1][st.memIndex], mem[0][st.memIndex]};
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // ************************************************************
    // Registers and storage
    // ************************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            st <= '0;
            st.cfg <= sdw_pkg::CFG_RESET;
        end else begin
            st <= next_st;
        end
    end

    // Storage has no reset: contents are undefined until written
    always_ff @(posedge clk) begin
        for (int l = 0; l < sdw_pkg::LANES; l++) begin
            if (memWe[l]) begin
                mem[l][memAddr[l]] <= capData[l]; // RULE_20
            end
        end
    end

    assign avs_waitrequest     = busReq & ~st.ack;
    assign avs_readdata        = st.readData;
    assign dataOut             = '0;
    assign dataOe              = 1'b0; // RULE_06
    assign autoPrechargeStrobe = st.apPulse;
    assign autoPrechargeBank   = st.apBank;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence burstEndsWithPre;
        burstDone && st.burst.autoPre && !st.recov.on;
    endsequence

    sequence preFiresLater;
        ##[1:8] autoPrechargeStrobe && autoPrechargeBank == $past(st.burst.bank, 1);
    endsequence

    wrSchedule_a: assert property (isWrite && writeLatency != 4'h0 && !avs_write
                                   |=> st.sched[writeLatency - 4'h1].valid) // RULE_01
        else $error("Write command not scheduled at its latency");
    bankTake_a: assert property (st.sched[0].valid |=> st.burst.on && st.burst.bank == $past(st.sched[0].bank)
                                 && st.burst.cnt == '0) // RULE_22
        else $error("Burst did not start with the scheduled bank");
    apSelect_a: assert property (st.sched[0].valid |=> st.burst.autoPre == $past(st.sched[0].autoPre)) // RULE_11
        else $error("Burst lost its auto precharge selection");
    idleDrop_a: assert property (!st.burst.on |-> memWe == '0) // RULE_06
        else $error("Array written outside a burst");
    maskBlock_a: assert property (capValid[0] && capMask[0] |-> !memWe[0]) // RULE_20
        else $error("Masked element was written");
    countLimit_a: assert property (st.burst.on |-> st.burst.cnt[0] <= st.burst.limit
                                   && st.burst.cnt[1] <= st.burst.limit) // RULE_03
        else $error("Lane element count passed the burst length");
    autoPre_a: assert property (burstEndsWithPre |-> preFiresLater) // RULE_02
        else $error("Auto precharge missing after burst");
    noPreOpen_a: assert property (st.burst.on && !st.burst.autoPre && !st.recov.on |=> !autoPrechargeStrobe) // RULE_02
        else $error("Precharge pulse without a pending recovery");
    recovTime_a: assert property (burstEndsWithPre and (recovery == 3'h3 && !avs_write)
                                  |-> ##4 autoPrechargeStrobe) // RULE_18
        else $error("Recovery count does not follow the mode field");
    truncate_a: assert property (st.burst.on && st.burst.limit == sdw_pkg::BURST_LONG && st.sched[0].valid
                                 |=> st.burst.cnt == '0 && st.burst.limit != 4'h0) // RULE_09
        else $error("Interrupting write did not take over the lanes");
    busWait_a: assert property ((avs_read || avs_write) && !st.ack |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("Bus answer not after exactly one wait state");
endmodule

// *** tb/sdw_ctl_model.sv ***
// Purpose: controller side, drives write commands and strobed data
// Assumes: slow strobes, each level held for several clocks
// Notes:   released data lines show the inverse of their last value
`timescale 1ns/1ns
module sdw_ctl_model (
    input  wire logic         clk,
    output sdw_pkg::sdw_cmd_t cmdPins,
    output logic [15:0]       dataIn,
    output logic [1:0]        byteMaskInput,
    output logic              lowerByteStrobe,
    output logic              upperByteStrobe
);
    // ********************************
    // Command and burst driver
    // ********************************
    localparam sdw_pkg::sdw_cmd_t IDLE = {5'b11111, 2'h0, 13'h0000};

    initial begin
        cmdPins = IDLE;
        dataIn = 16'h0000;
        byteMaskInput = 2'h0;
        lowerByteStrobe = 1'b0;
        upperByteStrobe = 1'b0;
    end

    // Never sends a read or a precharge, so no spacing to those can be broken
    task automatic issue(input sdw_pkg::sdw_cmd_t c);
        @(posedge clk);
        cmdPins <= c;
        @(posedge clk);
        cmdPins <= IDLE;
    endtask

    // Whole bursts only, never cut short from this side
    task automatic writeBurst(input logic [1:0] bank, input logic [3:0] col, input logic ap, input int wl,
                              input int n, input int hold, input logic [7:0][15:0] d, input logic [7:0][1:0] m);
        issue({5'b10100, bank, 2'h0, ap, 6'h00, col});
        repeat (wl) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            dataIn <= d[i];
            byteMaskInput <= m[i];
            lowerByteStrobe <= ~i[0];
            upperByteStrobe <= ~i[0];
            repeat (hold) @(posedge clk);
        end
        lowerByteStrobe <= 1'b0;
        upperByteStrobe <= 1'b0;
        dataIn <= ~d[n-1];
        byteMaskInput <= ~m[n-1];
    endtask
endmodule

// *** tb/sdw_write_burst_tb.sv ***
// Purpose: self-checking bench for the write-burst path
// Assumes: controller model keeps command spacing and slow strobes
// Notes:   stored words read back through index and data registers
`timescale 1ns/1ns
module sdw_write_burst_tb;
    logic              clk;
    logic              srst;
    logic [3:0]        avs_address;
    logic              avs_read;
    logic              avs_write;
    logic [31:0]       avs_writedata;
    logic [31:0]       avs_readdata;
    logic              avs_waitrequest;
    sdw_pkg::sdw_cmd_t cmdPins;
    logic [15:0]       dataIn;
    logic [15:0]       dataOut;
    logic [1:0]        byteMaskInput;
    logic [1:0]        autoPrechargeBank;
    logic              lowerByteStrobe;
    logic              upperByteStrobe;
    logic              dataOe;
    logic              autoPrechargeStrobe;
    logic [1:0]        apBank;
    int                apCount;
    int                err_total;
    int                comparisons;

    // ********************************
    // Harness and scenarios
    // ********************************
    sdw_write_burst dut_u (.clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
        .avs_waitrequest, .cmdPins, .dataIn, .byteMaskInput, .lowerByteStrobe, .upperByteStrobe, .dataOut,
        .dataOe, .autoPrechargeStrobe, .autoPrechargeBank);
    sdw_ctl_model ctl_u (.clk, .cmdPins, .dataIn, .byteMaskInput, .lowerByteStrobe, .upperByteStrobe);

    always #20 clk = ~clk;

    always @(posedge clk) begin
        if (autoPrechargeStrobe === 1'b1) begin
            apCount <= apCount + 1;
            apBank <= autoPrechargeBank;
        end
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Bounded wait: a stuck waitrequest ends the run
    task automatic busCycle(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] q);
        int k;
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= wd;
        for (k = 0; k < 50; k++) begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0) begin
                q = avs_readdata;
                break;
            end
        end
        if (k == 50) begin
            err_total++;
            wrap_up();
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic memCheck(input logic [5:0] idx, input logic [15:0] exp);
        logic [31:0] q;
        busCycle(1'b1, sdw_pkg::REG_MEM_INDEX, {26'h0, idx}, q);
        busCycle(1'b0, sdw_pkg::REG_MEM_DATA, 32'h0, q);
        check("stored word", q, {16'h0000, exp});
    endtask

    task automatic waitIdle();
        logic [31:0] q;
        q = 32'h1;
        for (int k = 0; k < 20 && q[0] !== 1'b0; k++) busCycle(1'b0, sdw_pkg::REG_STATUS, 32'h0, q);
        check("burst active", {31'h0, q[0]}, 32'h0);
    endtask

    task automatic regsReset();
        logic [31:0] q;
        busCycle(1'b0, sdw_pkg::REG_CFG, 32'h0, q);
        check("config reset", q, {20'h0, sdw_pkg::CFG_RESET});
        busCycle(1'b1, 4'h2, 32'hFFFF_FFFF, q);
        busCycle(1'b0, 4'h2, 32'h0, q);
        check("unmapped read", q, 32'h0);
    endtask

    // Eight edges against a four burst: the extra ones must be dropped
    task automatic burstPlain();
        logic [7:0][15:0] d;
        for (int i = 0; i < 8; i++) d[i] = {4'hA, i[3:0], 4'h5, i[3:0]};
        ctl_u.writeBurst(2'h1, 4'h5, 1'b0, 2, 8, 3, d, '0);
        waitIdle();
        for (int i = 0; i < 4; i++) memCheck({4'h5, 2'(i + 1)}, d[i]);
        check("data drive", {15'h0, dataOut, dataOe}, 32'h0);
    endtask

    task automatic burstMasked();
        logic [7:0][15:0] d;
        logic [7:0][15:0] old;
        logic [7:0][1:0]  m;
        m = {8'h00, 8'hE4};
        for (int i = 0; i < 8; i++) begin
            d[i] = {4'hC, i[3:0], 4'h3, i[3:0]};
            old[i] = {4'hA, i[3:0], 4'h5, i[3:0]};
        end
        ctl_u.writeBurst(2'h1, 4'h5, 1'b1, 2, 4, 4, d, m);
        waitIdle();
        for (int i = 0; i < 4; i++)
            memCheck({4'h5, 2'(i + 1)}, {m[i][1] ? old[i][15:8] : d[i][15:8], m[i][0] ? old[i][7:0] : d[i][7:0]});
        for (int k = 0; k < 40 && apCount == 0; k++) @(posedge clk);
        check("precharge count", apCount, 1);
        check("precharge bank", {30'h0, apBank}, 32'h1);
    endtask

    task automatic burstLong();
        logic [7:0][15:0] d;
        logic [31:0]      q;
        busCycle(1'b1, sdw_pkg::REG_CFG, 32'h0000_0531, q);
        busCycle(1'b0, sdw_pkg::REG_CFG, 32'h0, q);
        check("config", q, 32'h0000_0531);
        for (int i = 0; i < 8; i++) d[i] = {4'h7, i[3:0], 4'hE, i[3:0]};
        ctl_u.writeBurst(2'h2, 4'h3, 1'b0, 3, 8, 3, d, '0);
        waitIdle();
        for (int i = 0; i < 8; i++) memCheck({3'h4, 3'(i + 3)}, d[i]);
        check("precharge count", apCount, 1);
    endtask

    // Non-write patterns must not count as bursts
    task automatic decodeCount();
        logic [31:0] q;
        ctl_u.issue({5'b10011, 2'h3, 13'h0000});
        ctl_u.issue({5'b00100, 2'h3, 13'h0000});
        busCycle(1'b1, sdw_pkg::REG_STATUS, 32'hFFFF_FFFF, q);
        busCycle(1'b0, sdw_pkg::REG_STATUS, 32'h0, q);
        check("status", q & 32'h0000_FF31, 32'h0000_0320);
    endtask

    initial begin
        clk = 1'b0;
        srst = 1'b1;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        apBank = 2'h0;
        apCount = 0;
        err_total = 0;
        comparisons = 0;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        regsReset();
        burstPlain();
        burstMasked();
        burstLong();
        decodeCount();
        wrap_up();
    end
endmodule
